// ===== hdl/lbc_pkg.sv
// Package: constants and carriers for the logic block cell array
package lbc_pkg;
   localparam int LBC_NCELLS = 8;
   localparam int LBC_NGBUF = 8;
   localparam int LBC_LUT_IN = 4;
   localparam int LBC_LUT_SIZE = 16;
   // Configuration word layout per cell: table, output select
   localparam int LBC_CFG_W = 32;
   localparam int LBC_TBL_LSB = 0;
   localparam int LBC_REGSEL_BIT = 16;
   // Block control field positions
   localparam int LBC_CTL_SRUSE = 0;
   localparam int LBC_CTL_SRSYNC = 1;
   localparam int LBC_CTL_SRSET = 2;
   localparam int LBC_CTL_CEUSE = 3;
   localparam int LBC_CTL_CLKRT = 4;
   localparam int LBC_CTL_CESRC = 5;
   localparam int LBC_CTL_SRSRC = 6;
   localparam int LBC_CTL_GLU = 7;
   localparam int LBC_CTL_CKSEL = 8;
   localparam int LBC_CTL_CESEL = 11;
   localparam int LBC_CTL_SRSEL = 13;
   localparam int LBC_CTL_GLSEL = 16;
   // Register offsets: cells 0..7 at 0x00..0x1C, control at 0x20, status at 0x24
   localparam logic [7:0] LBC_OFS_CELL0 = 8'h00;
   localparam logic [7:0] LBC_OFS_CTRL = 8'h20;
   localparam logic [7:0] LBC_OFS_STAT = 8'h24;
   localparam logic [7:0] LBC_OFS_CFGD = 8'h28;
   localparam logic [31:0] LBC_CFG_RST = 32'h0000_0000;
   localparam logic [31:0] LBC_CTRL_RST = 32'h0000_0000;

   typedef struct packed {
      logic [LBC_LUT_IN-1:0] lut_in;
      logic carry_in_fast;
   } lbc_cell_in_t;

   typedef struct packed {
      logic lut_out;
      logic carry_out_fast;
   } lbc_cell_out_t;

   typedef enum logic [2:0] {
      LBC_CONFIG = 3'h1,
      LBC_WAKE = 3'h2,
      LBC_RUN = 3'h4
   } lbc_state_t;
endpackage : lbc_pkg

// ===== hdl/lbc_cell.sv
// Logic cell: four-input lookup table and fast carry
`timescale 1ns/1ns
`default_nettype none
module lbc_cell
   import lbc_pkg::*;
(
   // Configuration
   input wire logic [LBC_LUT_SIZE-1:0] i_table,
   // Cell data
   input wire lbc_cell_in_t i_in,
   output lbc_cell_out_t o_out
);
   always_comb begin
      o_out.lut_out = i_table[i_in.lut_in];
      // Majority of carry in with the two middle lookup inputs
      o_out.carry_out_fast = (i_in.carry_in_fast & i_in.lut_in[1])
         | (i_in.carry_in_fast & i_in.lut_in[2])
         | (i_in.lut_in[1] & i_in.lut_in[2]);
   end
endmodule : lbc_cell
`default_nettype wire

// ===== hdl/lbc_block.sv
// Logic block: eight cells, shared clock enable and set/reset, register port
`timescale 1ns/1ns
`default_nettype none
module lbc_block
   import lbc_pkg::*;
#(
   parameter int NCELLS = LBC_NCELLS
)(
   // Clock and reset
   input wire logic i_mclk,
   input wire logic i_nrst,
   // Register port
   input wire logic [7:0] i_addr,
   input wire logic [31:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [31:0] o_rdata,
   // Fabric inputs
   input wire logic [LBC_NGBUF-1:0] i_global_buffer_line,
   input wire logic i_route_clk,
   input wire logic i_route_ce,
   input wire logic i_route_sr,
   input wire logic [NCELLS*LBC_LUT_IN-1:0] i_lut_in,
   input wire logic i_carry_in_fast,
   // Fabric outputs
   output logic [NCELLS-1:0] o_cell_out,
   output logic o_carry_out_fast
);
   ////////////////////////////////////////////////////////////////////
   // Configuration state
   logic [31:0] cfg_q [NCELLS];
   logic [31:0] ctrl_q;
   lbc_state_t state_q;
   logic cfg_done_q;
   logic [NCELLS-1:0] ff_q;
   logic glob_rst;
   logic [LBC_NGBUF-1:0] gb_s1_q, gb_s2_q;
   logic [2:0] rt_s1_q, rt_s2_q;
   logic [LBC_NGBUF-1:0] gb_prev_q;
   logic rt_clk_prev_q;
   logic [31:0] rdata_d;
   logic [NCELLS-1:0] lut_vec;

   // Global lines and routed clock, enable and set/reset arrive from another timing domain; two flops first
   always_ff @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) begin
         gb_s1_q <= 8'h00;
         gb_s2_q <= 8'h00;
         rt_s1_q <= 3'h0;
         rt_s2_q <= 3'h0;
      end else begin
         gb_s1_q <= i_global_buffer_line;
         gb_s2_q <= gb_s1_q;
         rt_s1_q <= {i_route_sr, i_route_ce, i_route_clk};
         rt_s2_q <= rt_s1_q;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Configuration sequence: hold global reset until software marks done
   always_ff @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) begin
         state_q <= LBC_CONFIG;
      end else begin
         case (state_q)
            LBC_CONFIG: if (cfg_done_q) state_q <= LBC_WAKE;
            LBC_WAKE: state_q <= LBC_RUN;
            LBC_RUN: if (!cfg_done_q) state_q <= LBC_CONFIG;
            default: state_q <= LBC_CONFIG;
         endcase
      end
   end

   // Asserted in configuration and for one wake cycle right after it
   assign glob_rst = (state_q != LBC_RUN);

   ////////////////////////////////////////////////////////////////////
   // Register writes
   always_ff @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) begin
         for (int i = 0; i < NCELLS; i++) cfg_q[i] <= LBC_CFG_RST;
         ctrl_q <= LBC_CTRL_RST;
         cfg_done_q <= 1'b0;
      end else if (i_wr) begin
         for (int i = 0; i < NCELLS; i++) begin
            if (i_addr == LBC_OFS_CELL0 + 8'(4 * i)) cfg_q[i] <= i_wdata;
         end
         if (i_addr == LBC_OFS_CTRL) ctrl_q <= i_wdata;
         if (i_addr == LBC_OFS_CFGD) cfg_done_q <= i_wdata[0];
      end
   end

   // Read data valid only in the cycle after the strobe
   always_comb begin
      rdata_d = 32'h0000_0000;
      for (int i = 0; i < NCELLS; i++) begin
         if (i_addr == LBC_OFS_CELL0 + 8'(4 * i)) rdata_d = cfg_q[i];
      end
      if (i_addr == LBC_OFS_CTRL) rdata_d = ctrl_q;
      if (i_addr == LBC_OFS_CFGD) rdata_d = {31'h0, cfg_done_q};
      if (i_addr == LBC_OFS_STAT) rdata_d = {21'h0, state_q, ff_q};
   end

   always_ff @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) o_rdata <= 32'h0000_0000;
      else if (i_rd) o_rdata <= rdata_d;
      else o_rdata <= 32'h0000_0000;
   end

   ////////////////////////////////////////////////////////////////////
   // Control source selection
   logic [2:0] ck_sel;
   logic [1:0] ce_sel, sr_sel;
   logic blk_clk, blk_ce, blk_sr, clk_rise;
   assign ck_sel = ctrl_q[LBC_CTL_CKSEL +: 3];
   assign ce_sel = ctrl_q[LBC_CTL_CESEL +: 2];
   assign sr_sel = ctrl_q[LBC_CTL_SRSEL +: 2];

   always_comb begin
      // Any global line or general routing may clock the block
      blk_clk = ctrl_q[LBC_CTL_CLKRT] ? rt_s2_q[0] : gb_s2_q[ck_sel];
      // Only odd lines reach enable, only even lines reach set/reset
      blk_ce = ctrl_q[LBC_CTL_CESRC] ? gb_s2_q[{ce_sel, 1'b1}] : rt_s2_q[1];
      blk_sr = ctrl_q[LBC_CTL_SRSRC] ? gb_s2_q[{sr_sel, 1'b0}] : rt_s2_q[2];
   end

   // Block clock is sampled; an edge is a rising transition of it
   always_ff @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) begin
         gb_prev_q <= 8'h00;
         rt_clk_prev_q <= 1'b0;
      end else begin
         gb_prev_q <= gb_s2_q;
         rt_clk_prev_q <= rt_s2_q[0];
      end
   end
   assign clk_rise = ctrl_q[LBC_CTL_CLKRT] ? (rt_s2_q[0] & ~rt_clk_prev_q)
                                           : (gb_s2_q[ck_sel] & ~gb_prev_q[ck_sel]);

   ////////////////////////////////////////////////////////////////////
   // Cells and carry chain
   lbc_cell_in_t cin [NCELLS];
   lbc_cell_out_t cout [NCELLS];
   logic [NCELLS:0] carry;
   logic [LBC_LUT_IN-1:0] glue_in;
   assign carry[0] = i_carry_in_fast;
   // Four global lines picked for lookup inputs when glue mode is on
   always_comb begin
      glue_in = '0;
      for (int k = 0; k < LBC_LUT_IN; k++) begin
         glue_in[k] = gb_s2_q[ctrl_q[LBC_CTL_GLSEL + 3*k +: 3]];
      end
   end

   for (genvar g = 0; g < NCELLS; g++) begin : g_cell
      assign cin[g].lut_in = ctrl_q[LBC_CTL_GLU] ? glue_in
                                                 : i_lut_in[g*LBC_LUT_IN +: LBC_LUT_IN];
      assign cin[g].carry_in_fast = carry[g];
      lbc_cell u_cell (
         .i_table(cfg_q[g][LBC_TBL_LSB +: LBC_LUT_SIZE]),
         .i_in(cin[g]),
         .o_out(cout[g])
      );
      assign carry[g+1] = cout[g].carry_out_fast;
   end

   // Lookup results gathered into one vector for the flop checks
   always_comb begin
      lut_vec = '0;
      for (int i = 0; i < NCELLS; i++) begin
         lut_vec[i] = cout[i].lut_out;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Flip-flops: global reset first, then async or sync local set/reset
   logic sr_use, sr_async_hit, sr_sync_hit, ff_tick;
   assign sr_use = ctrl_q[LBC_CTL_SRUSE];
   assign sr_async_hit = sr_use & ~ctrl_q[LBC_CTL_SRSYNC] & blk_sr;
   assign sr_sync_hit = sr_use & ctrl_q[LBC_CTL_SRSYNC] & blk_sr & clk_rise;
   // One shared enable; unused enable means always enabled
   assign ff_tick = clk_rise & (~ctrl_q[LBC_CTL_CEUSE] | blk_ce);

   always_ff @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) begin
         ff_q <= '0;
      end else if (glob_rst) begin
         ff_q <= '0;
      end else if (sr_async_hit) begin
         // Level-sensitive: held as long as the set/reset is high
         ff_q <= {NCELLS{ctrl_q[LBC_CTL_SRSET]}};
      end else if (sr_sync_hit) begin
         ff_q <= {NCELLS{ctrl_q[LBC_CTL_SRSET]}};
      end else if (ff_tick) begin
         // Data only: no set/reset path when unused
         for (int i = 0; i < NCELLS; i++) ff_q[i] <= cout[i].lut_out;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Outputs registered once more so every port comes from a flop
   always_ff @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_cell_out <= '0;
         o_carry_out_fast <= 1'b0;
      end else begin
         for (int i = 0; i < NCELLS; i++) begin
            o_cell_out[i] <= cfg_q[i][LBC_REGSEL_BIT] ? ff_q[i] : cout[i].lut_out;
         end
         o_carry_out_fast <= carry[NCELLS];
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Checks
   sequence s_cfg_drop;
      cfg_done_q ##1 !cfg_done_q;
   endsequence

   chk_wake_clear: assert property (@(posedge i_mclk) disable iff (!i_nrst)
      state_q == LBC_WAKE |=> ff_q == '0) else $error("flops not clear after wake");
   chk_config_hold: assert property (@(posedge i_mclk) disable iff (!i_nrst)
      s_cfg_drop |=> ##1 (ff_q == '0)) else $error("reset not held in config");
   chk_no_tick_hold: assert property (@(posedge i_mclk) disable iff (!i_nrst)
      (!glob_rst && !sr_use && !clk_rise) |=> $stable(ff_q)) else $error("flop moved");
   chk_ce_gate: assert property (@(posedge i_mclk) disable iff (!i_nrst)
      (!glob_rst && !sr_use && ctrl_q[LBC_CTL_CEUSE] && !blk_ce) |=> $stable(ff_q))
      else $error("enable ignored");
   chk_async_sr: assert property (@(posedge i_mclk) disable iff (!i_nrst)
      (!glob_rst && sr_async_hit) |=> ff_q == {NCELLS{$past(ctrl_q[LBC_CTL_SRSET])}})
      else $error("async set/reset missed");
   chk_sync_sr: assert property (@(posedge i_mclk) disable iff (!i_nrst)
      (!glob_rst && sr_use && ctrl_q[LBC_CTL_SRSYNC] && blk_sr && !clk_rise)
      |=> $stable(ff_q)) else $error("sync set/reset acted without edge");
   chk_lut_read: assert property (@(posedge i_mclk) disable iff (!i_nrst)
      !cfg_q[0][LBC_REGSEL_BIT] |=> o_cell_out[0] == $past(cout[0].lut_out))
      else $error("lookup output wrong");
   chk_carry_maj: assert property (@(posedge i_mclk) disable iff (!i_nrst)
      (carry[0] && cin[0].lut_in[1]) |-> carry[1]) else $error("carry majority");
   chk_rd_resp: assert property (@(posedge i_mclk) disable iff (!i_nrst)
      !i_rd |=> o_rdata == 32'h0000_0000) else $error("read data outside slot");

   ////////////////////////////////////////////////////////////////////
   // Configuration sequence checks
   sequence s_wake_steps;
      state_q == LBC_WAKE ##1 state_q == LBC_RUN;
   endsequence

   sequence s_cfg_start;
      state_q == LBC_CONFIG && cfg_done_q;
   endsequence

   chk_wake_steps: assert property (@(posedge i_mclk) disable iff (!i_nrst)
      s_cfg_start |=> s_wake_steps) else $error("wake sequence broken");

   chk_cfg_return: assert property (@(posedge i_mclk) disable iff (!i_nrst)
      (state_q == LBC_RUN && !cfg_done_q) |=> state_q == LBC_CONFIG)
      else $error("no return to config");

   chk_state_onehot: assert property (@(posedge i_mclk) disable iff (!i_nrst)
      $onehot(state_q)) else $error("state code not one-hot");

   chk_cfg_clear: assert property (@(posedge i_mclk) disable iff (!i_nrst)
      state_q == LBC_CONFIG |=> ff_q == '0) else $error("flops moved in config");

   chk_cfg_done_wr: assert property (@(posedge i_mclk) disable iff (!i_nrst)
      (i_wr && i_addr == LBC_OFS_CFGD) |=> cfg_done_q == $past(i_wdata[0]))
      else $error("config done write lost");

   ////////////////////////////////////////////////////////////////////
   // Register port checks
   chk_wr_cell: assert property (@(posedge i_mclk) disable iff (!i_nrst)
      (i_wr && i_addr == LBC_OFS_CELL0) |=> cfg_q[0] == $past(i_wdata))
      else $error("cell word write lost");

   chk_wr_ctrl: assert property (@(posedge i_mclk) disable iff (!i_nrst)
      (i_wr && i_addr == LBC_OFS_CTRL) |=> ctrl_q == $past(i_wdata))
      else $error("control write lost");

   chk_rd_ctrl: assert property (@(posedge i_mclk) disable iff (!i_nrst)
      (i_rd && i_addr == LBC_OFS_CTRL) |=> o_rdata == $past(ctrl_q))
      else $error("control read wrong");

   chk_rd_stat: assert property (@(posedge i_mclk) disable iff (!i_nrst)
      (i_rd && i_addr == LBC_OFS_STAT) |=> o_rdata[7:0] == $past(ff_q))
      else $error("status flops wrong");

   ////////////////////////////////////////////////////////////////////
   // Flop behaviour checks
   chk_tick_load: assert property (@(posedge i_mclk) disable iff (!i_nrst)
      (!glob_rst && !sr_async_hit && !sr_sync_hit && ff_tick) |=> ff_q == $past(lut_vec))
      else $error("flops missed data");

   chk_sync_load: assert property (@(posedge i_mclk) disable iff (!i_nrst)
      (!glob_rst && !sr_async_hit && sr_sync_hit)
      |=> ff_q == {NCELLS{$past(ctrl_q[LBC_CTL_SRSET])}}) else $error("sync set/reset missed");

   chk_no_sr_unused: assert property (@(posedge i_mclk) disable iff (!i_nrst)
      !sr_use |-> !(sr_async_hit || sr_sync_hit)) else $error("unused set/reset acted");

   chk_sr_even: assert property (@(posedge i_mclk) disable iff (!i_nrst)
      (sr_use && !ctrl_q[LBC_CTL_SRSYNC] && ctrl_q[LBC_CTL_SRSRC]
       && gb_s2_q[{sr_sel, 1'b0}]) |-> sr_async_hit) else $error("even line set/reset");

   chk_ce_odd: assert property (@(posedge i_mclk) disable iff (!i_nrst)
      (ctrl_q[LBC_CTL_CEUSE] && ctrl_q[LBC_CTL_CESRC] && !gb_s2_q[{ce_sel, 1'b1}])
      |-> !ff_tick) else $error("odd line enable ignored");

   ////////////////////////////////////////////////////////////////////
   // Output and carry checks
   chk_reg_out: assert property (@(posedge i_mclk) disable iff (!i_nrst)
      cfg_q[0][LBC_REGSEL_BIT] |=> o_cell_out[0] == $past(ff_q[0]))
      else $error("registered output wrong");

   chk_carry_out: assert property (@(posedge i_mclk) disable iff (!i_nrst)
      1'b1 |=> o_carry_out_fast == $past(carry[NCELLS])) else $error("carry out lost");

   chk_carry_cell1: assert property (@(posedge i_mclk) disable iff (!i_nrst)
      (carry[1] && cin[1].lut_in[2]) |-> carry[2]) else $error("carry ripple");

   chk_carry_low: assert property (@(posedge i_mclk) disable iff (!i_nrst)
      (!carry[0] && !cin[0].lut_in[1] && !cin[0].lut_in[2]) |-> !carry[1])
      else $error("carry set without majority");

   // Glue mode must override the routed lookup inputs; checked on the last cell
   chk_glue_in: assert property (@(posedge i_mclk) disable iff (!i_nrst)
      ctrl_q[LBC_CTL_GLU] |-> cin[NCELLS-1].lut_in == glue_in)
      else $error("glue inputs not used");
endmodule : lbc_block
`default_nettype wire

// ===== verif/lbc_fabric_model.sv
// Fabric partner: routing or global line clock pulses into the block
`timescale 1ns/1ns
`default_nettype none
module lbc_fabric_model
   import lbc_pkg::*;
(
   // Clock and request
   input wire logic i_mclk,
   input wire logic i_go,
   input wire logic [3:0] i_src,
   // Fabric wires
   output logic o_route_clk,
   output logic [LBC_NGBUF-1:0] o_gline
);
   // Lines stand low between pulses, so no stray block edge appears
   initial begin
      o_route_clk = 1'b0;
      o_gline = '0;
      forever begin
         @(posedge i_mclk);
         if (i_go) begin
            if (i_src[3])
               o_route_clk <= 1'b1;
            else
               o_gline[i_src[2:0]] <= 1'b1;
            repeat (4) @(posedge i_mclk);
            o_route_clk <= 1'b0;
            o_gline <= '0;
         end
      end
   end
endmodule : lbc_fabric_model
`default_nettype wire

// ===== verif/lbc_block_test.sv
// Self-checking bench for the logic block cell array
`timescale 1ns/1ns
`default_nettype none
module lbc_block_test;
   import lbc_pkg::*;
   logic i_mclk, i_nrst, i_wr, i_rd, i_route_ce, i_route_sr, i_carry_in_fast, go, rclk;
   logic o_carry_out_fast;
   logic [7:0] i_addr, gl, o_cell_out;
   logic [31:0] i_wdata, o_rdata, i_lut_in;
   logic [3:0] src;
   logic [15:0] tbl [8];
   int errors = 0;
   int checks = 0;
   lbc_block u_dut (.i_mclk(i_mclk), .i_nrst(i_nrst), .i_addr(i_addr), .i_wdata(i_wdata),
      .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_global_buffer_line(gl),
      .i_route_clk(rclk), .i_route_ce(i_route_ce), .i_route_sr(i_route_sr),
      .i_lut_in(i_lut_in), .i_carry_in_fast(i_carry_in_fast), .o_cell_out(o_cell_out),
      .o_carry_out_fast(o_carry_out_fast));
   lbc_fabric_model u_fab (.i_mclk(i_mclk), .i_go(go), .i_src(src), .o_route_clk(rclk),
      .o_gline(gl));
   initial begin
      i_mclk = 1'b0;
      forever #10 i_mclk = ~i_mclk;
   end
   ////////////////////////////////////////////////////////////
   task automatic conclude;
      if (errors == 0 && checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : conclude
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checks++;
      if (g !== e) begin
         errors++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   function automatic logic [7:0] luts(input logic [31:0] x);
      for (int g = 0; g < 8; g++)
         luts[g] = tbl[g][x[4*g+:4]];
   endfunction : luts
   // Ripple through all eight cells, majority of carry and lookup inputs 1 and 2
   function automatic logic cry(input logic c0, input logic [31:0] x);
      cry = c0;
      for (int g = 0; g < 8; g++)
         cry = (cry & x[4*g+1]) | (cry & x[4*g+2]) | (x[4*g+1] & x[4*g+2]);
   endfunction : cry
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge i_mclk);
      i_wr <= 1'b1;
      i_addr <= a;
      i_wdata <= d;
      @(posedge i_mclk);
      i_wr <= 1'b0;
   endtask : wr
   task automatic st(input logic [7:0] f, input logic [2:0] s);
      @(posedge i_mclk);
      i_rd <= 1'b1;
      i_addr <= LBC_OFS_STAT;
      @(posedge i_mclk);
      i_rd <= 1'b0;
      #1 chk("status", {21'h0, s, f}, o_rdata & 32'h7FF);
   endtask : st
   task automatic cfg(input logic [15:0] t, input logic rs, input logic rnd);
      for (int g = 0; g < 8; g++) begin
         tbl[g] = rnd ? 16'($urandom) : t;
         wr(LBC_OFS_CELL0 + 8'(4 * g), {15'h0, rs, tbl[g]});
      end
   endtask : cfg
   // Block clock edge from routing (8) or a global line (0..7)
   task automatic tick(input logic [3:0] s);
      @(posedge i_mclk);
      go <= 1'b1;
      src <= s;
      @(posedge i_mclk);
      go <= 1'b0;
      repeat (12) @(posedge i_mclk);
   endtask : tick
   ////////////////////////////////////////////////////////////
   initial begin
      repeat (20000) @(posedge i_mclk);
      errors++;
      conclude();
   end
   initial begin
      logic [31:0] x;
      logic c;
      {i_nrst, i_wr, i_rd, i_route_ce, i_route_sr, i_carry_in_fast, go} = '0;
      {i_addr, i_wdata, i_lut_in, src} = '0;
      void'($urandom(32'h29C5));
      repeat (4) @(posedge i_mclk);
      i_nrst <= 1'b1;
      st(8'h00, 3'h1);
      wr(8'h3C, 32'hFFFF_FFFF);
      st(8'h00, 3'h1);
      for (int k = 0; k < 40; k++) begin
         cfg(16'hFFFF, 1'b0, k != 0);
         x = (k == 1) ? 32'hFFFF_FFFF : $urandom;
         c = 1'($urandom);
         @(posedge i_mclk);
         i_lut_in <= x;
         i_carry_in_fast <= c;
         @(posedge i_mclk);
         #1 chk("cell_out", {24'h0, luts(x)}, {24'h0, o_cell_out});
         chk("carry", {31'h0, cry(c, x)}, {31'h0, o_carry_out_fast});
      end
      // Flops held clear until configuration is done
      cfg(16'hFFFF, 1'b1, 1'b0);
      wr(LBC_OFS_CTRL, 32'h10);
      tick(4'h8);
      st(8'h00, 3'h1);
      wr(LBC_OFS_CFGD, 32'h1);
      repeat (4) @(posedge i_mclk);
      tick(4'h8);
      st(8'hFF, 3'h4);
      chk("reg_out", 32'hFF, {24'h0, o_cell_out});
      cfg(16'h0, 1'b1, 1'b1);
      x = $urandom;
      i_lut_in <= x;
      tick(4'h8);
      st(luts(x), 3'h4);
      wr(LBC_OFS_CTRL, 32'h18);
      i_lut_in <= ~x;
      tick(4'h8);
      st(luts(x), 3'h4);
      wr(LBC_OFS_CTRL, 32'h38);
      i_route_ce <= 1'b1;
      tick(4'h8);
      st(luts(x), 3'h4);
      wr(LBC_OFS_CTRL, 32'h18);
      tick(4'h8);
      st(luts(~x), 3'h4);
      wr(LBC_OFS_CTRL, 32'h10);
      i_route_sr <= 1'b1;
      repeat (6) @(posedge i_mclk);
      st(luts(~x), 3'h4);
      wr(LBC_OFS_CTRL, 32'h15);
      repeat (6) @(posedge i_mclk);
      st(8'hFF, 3'h4);
      wr(LBC_OFS_CTRL, 32'h13);
      repeat (6) @(posedge i_mclk);
      st(8'hFF, 3'h4);
      tick(4'h8);
      st(8'h00, 3'h4);
      i_route_sr <= 1'b0;
      wr(LBC_OFS_CTRL, 32'h500);
      tick(4'h3);
      st(8'h00, 3'h4);
      tick(4'h5);
      st(luts(~x), 3'h4);
      // Glue mode: idle global lines address entry 0, routed inputs entry 15
      cfg(16'h0001, 1'b0, 1'b0);
      i_lut_in <= 32'hFFFF_FFFF;
      wr(LBC_OFS_CTRL, 32'h80);
      repeat (2) @(posedge i_mclk);
      #1 chk("glue", 32'hFF, {24'h0, o_cell_out});
      // Even line 0 sets asynchronously and beats the clock edge on the same line
      wr(LBC_OFS_CTRL, 32'h45);
      tick(4'h0);
      st(8'hFF, 3'h4);
      conclude();
   end
endmodule : lbc_block_test
`default_nettype wire
